// ---- mcx_pkg.sv ----
// constants and types shared by the instruction slice executor
package mcx_pkg;
    // operation codes as handed over by the fetch/decode stage
    typedef enum logic [2:0] {
        MCX_SOFT_INT = 3'h0,
        MCX_OR_IMMEDIATE_OP = 3'h1,
        MCX_OR_REGISTER_OP = 3'h2,
        MCX_WRITE_SPECIAL_PAGE_OP = 3'h3,
        MCX_READ_SPECIAL_PAGE_OP = 3'h4,
        MCX_LONG_JUMP_OP = 3'h5,
        MCX_LONG_CALL_OP = 3'h6,
        MCX_STORE_ACCUMULATOR_OP = 3'h7
    } mcx_op_t;

    localparam int MCX_PC_W = 11;
    localparam int MCX_DATA_W = 8;
    localparam int MCX_RADDR_W = 7;
    localparam int MCX_SFR_IDX_W = 4;
    // software interrupt target address
    localparam logic [10:0] MCX_INT_VECTOR = 11'h001;
    // valid special page window
    localparam logic [3:0] MCX_SFR_LO = 4'h5;
    localparam logic [3:0] MCX_SFR_HI = 4'hF;
    // reset values
    localparam logic [10:0] MCX_PC_RST = 11'h000;
    localparam logic [7:0] MCX_ACC_RST = 8'h00;
    localparam logic [7:0] MCX_SFR_RST = 8'h00;
    // extra stall cycles after issue (total cycles minus one)
    localparam logic [1:0] MCX_STALL_INT = 2'h2;
    localparam logic [1:0] MCX_STALL_BRANCH = 2'h1;
endpackage

// ---- mcx_data_mem.sv ----
// data register file, synchronous write, registered read
`timescale 1ns/1ps
`default_nettype none
module mcx_data_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 128
) (
    // clock
    input wire logic clk,
    // read port
    input wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data,
    // write port
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    // write, and read of the old contents
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule
`default_nettype wire

// ---- mcx_exec.sv ----
// execution logic for a slice of an 8-bit core's instruction set
`timescale 1ns/1ps
`default_nettype none
module mcx_exec #(
    parameter int STACK_DEPTH = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // decoded instruction
    input wire logic insn_valid,
    input wire mcx_pkg::mcx_op_t insn_op,
    input wire logic [10:0] insn_imm,
    input wire logic insn_dest,
    // core state
    output logic insn_ready,
    output logic retire,
    output logic [10:0] pc,
    output logic [7:0] accumulator,
    output logic zero_flag,
    output logic [$clog2(STACK_DEPTH)-1:0] stack_ptr,
    output logic [10:0] stack_top
);
    import mcx_pkg::*;

    localparam int SP_W = $clog2(STACK_DEPTH);

    initial begin
        if (STACK_DEPTH < 2 || (1 << SP_W) != STACK_DEPTH) begin
            $error("STACK_DEPTH must be a power of two of at least 2");
        end
    end

    logic ex_valid_r;
    mcx_op_t ex_op_r;
    logic [10:0] ex_imm_r;
    logic ex_dest_r;
    logic fwd_hit_r;
    logic [7:0] fwd_data_r;
    logic [1:0] wait_r;
    logic [7:0] mem_rdata;
    logic [7:0] operand;
    logic [7:0] or_result;
    logic mem_we;
    logic [7:0] mem_wdata;
    logic issue;
    logic sfr_ok;
    logic [3:0] sfr_idx;
    logic [7:0] sfr_r [16];

    // register index lies in the documented special page window
    function automatic logic sfr_in_range(input logic [3:0] idx);
        return idx >= MCX_SFR_LO && idx <= MCX_SFR_HI;
    endfunction

    assign issue = insn_valid && insn_ready;
    assign operand = fwd_hit_r ? fwd_data_r : mem_rdata;
    assign or_result = accumulator | operand;
    assign sfr_idx = ex_imm_r[3:0];
    assign sfr_ok = sfr_in_range(sfr_idx);

    // data register write from the execute stage
    always_comb begin
        mem_we = 1'b0;
        mem_wdata = accumulator;
        if (ex_valid_r && ex_op_r == MCX_OR_REGISTER_OP && ex_dest_r) begin
            mem_we = 1'b1;
            mem_wdata = or_result;
        end else if (ex_valid_r && ex_op_r == MCX_STORE_ACCUMULATOR_OP) begin
            mem_we = 1'b1;
        end
    end

    mcx_data_mem #(
        .WIDTH(8),
        .DEPTH(128)
    ) u_mem (
        .clk(ref_clk),
        .rd_addr(insn_imm[6:0]),
        .rd_data(mem_rdata),
        .wr_en(mem_we),
        .wr_addr(ex_imm_r[6:0]),
        .wr_data(mem_wdata)
    );

    // issue stage latch; bypass a write that the memory read missed
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ex_valid_r <= 1'b0;
            ex_op_r <= MCX_SOFT_INT;
            ex_imm_r <= 11'h000;
            ex_dest_r <= 1'b0;
            fwd_hit_r <= 1'b0;
            fwd_data_r <= 8'h00;
        end else begin
            ex_valid_r <= issue;
            if (issue) begin
                ex_op_r <= insn_op;
                ex_imm_r <= insn_imm;
                ex_dest_r <= insn_dest;
                fwd_hit_r <= mem_we && ex_imm_r[6:0] == insn_imm[6:0];
                fwd_data_r <= mem_wdata;
            end
        end
    end

    // issue pacing: multi-cycle ops hold off the next instruction
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            insn_ready <= 1'b1;
            wait_r <= 2'h0;
        end else if (issue && insn_op == MCX_SOFT_INT) begin
            insn_ready <= 1'b0;
            wait_r <= MCX_STALL_INT - 2'h1;
        end else if (issue && (insn_op == MCX_LONG_JUMP_OP ||
                               insn_op == MCX_LONG_CALL_OP)) begin
            insn_ready <= 1'b0;
            wait_r <= MCX_STALL_BRANCH - 2'h1;
        end else if (!insn_ready) begin
            if (wait_r == 2'h0) begin
                insn_ready <= 1'b1;
            end else begin
                wait_r <= wait_r - 2'h1;
            end
        end
    end

    // accumulator and zero flag
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            accumulator <= MCX_ACC_RST;
            zero_flag <= 1'b0;
        end else if (ex_valid_r) begin
            unique case (ex_op_r)
                MCX_OR_IMMEDIATE_OP: begin
                    accumulator <= accumulator | ex_imm_r[7:0];
                    zero_flag <= (accumulator | ex_imm_r[7:0]) == 8'h00;
                end
                MCX_OR_REGISTER_OP: begin
                    if (!ex_dest_r) begin
                        accumulator <= or_result;
                    end
                    zero_flag <= or_result == 8'h00;
                end
                MCX_READ_SPECIAL_PAGE_OP: begin
                    if (sfr_ok) begin
                        accumulator <= sfr_r[sfr_idx];
                    end
                end
                default: begin
                    accumulator <= accumulator;
                end
            endcase
        end
    end

    // special page registers, written only inside the valid window
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 16; i++) begin
                sfr_r[i] <= MCX_SFR_RST;
            end
        end else if (ex_valid_r && ex_op_r == MCX_WRITE_SPECIAL_PAGE_OP &&
                     sfr_ok) begin
            sfr_r[sfr_idx] <= accumulator;
        end
    end

    // program counter, stack and retire pulse
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pc <= MCX_PC_RST;
            stack_ptr <= '0;
            stack_top <= MCX_PC_RST;
            retire <= 1'b0;
        end else begin
            retire <= ex_valid_r;
            if (ex_valid_r) begin
                unique case (ex_op_r)
                    MCX_SOFT_INT, MCX_LONG_CALL_OP: begin
                        stack_top <= pc + 11'h001;
                        stack_ptr <= stack_ptr + 1'b1;
                        pc <= (ex_op_r == MCX_SOFT_INT) ? MCX_INT_VECTOR
                                                        : ex_imm_r;
                    end
                    MCX_LONG_JUMP_OP: begin
                        pc <= ex_imm_r;
                    end
                    default: begin
                        pc <= pc + 11'h001;
                    end
                endcase
            end
        end
    end

    // checks
    sequence s_hold_one;
        !insn_ready ##1 insn_ready;
    endsequence

    sequence s_hold_two;
        !insn_ready [*2] ##1 insn_ready;
    endsequence

    property p_int_timing;
        @(posedge ref_clk) disable iff (!resetn)
        issue && insn_op == MCX_SOFT_INT |=> s_hold_two;
    endproperty
    a_int_timing: assert property (p_int_timing)
        else $error("software interrupt does not take three cycles");

    property p_int_vector;
        @(posedge ref_clk) disable iff (!resetn)
        ex_valid_r && ex_op_r == MCX_SOFT_INT |=>
            pc == MCX_INT_VECTOR && stack_top == $past(pc) + 11'h001;
    endproperty
    a_int_vector: assert property (p_int_vector)
        else $error("software interrupt vector or return address wrong");

    property p_or_imm;
        @(posedge ref_clk) disable iff (!resetn)
        issue && insn_op == MCX_OR_IMMEDIATE_OP |=> insn_ready ##0
            (ex_valid_r ##1 accumulator == ($past(accumulator)
                                           | $past(ex_imm_r[7:0])));
    endproperty
    a_or_imm: assert property (p_or_imm)
        else $error("OR immediate result or timing wrong");

    property p_or_reg;
        @(posedge ref_clk) disable iff (!resetn)
        ex_valid_r && ex_op_r == MCX_OR_REGISTER_OP |=>
            zero_flag == ($past(or_result) == 8'h00) &&
            accumulator == ($past(ex_dest_r) ? $past(accumulator)
                                             : $past(or_result));
    endproperty
    a_or_reg: assert property (p_or_reg)
        else $error("OR register result or zero flag wrong");

    property p_no_flags;
        @(posedge ref_clk) disable iff (!resetn)
        ex_valid_r && (ex_op_r == MCX_WRITE_SPECIAL_PAGE_OP ||
                       ex_op_r == MCX_STORE_ACCUMULATOR_OP) |=>
            $stable(accumulator) && $stable(zero_flag);
    endproperty
    a_no_flags: assert property (p_no_flags)
        else $error("write op disturbed accumulator or flag");

    property p_sfr_read;
        @(posedge ref_clk) disable iff (!resetn)
        ex_valid_r && ex_op_r == MCX_READ_SPECIAL_PAGE_OP |=>
            $stable(zero_flag) && accumulator == ($past(sfr_ok) ?
                $past(sfr_r[sfr_idx]) : $past(accumulator));
    endproperty
    a_sfr_read: assert property (p_sfr_read)
        else $error("special page read wrong");

    property p_branch;
        @(posedge ref_clk) disable iff (!resetn)
        issue && (insn_op == MCX_LONG_JUMP_OP ||
                  insn_op == MCX_LONG_CALL_OP) |=> s_hold_one;
    endproperty
    a_branch: assert property (p_branch)
        else $error("long branch does not take two cycles");

    property p_call;
        @(posedge ref_clk) disable iff (!resetn)
        ex_valid_r && ex_op_r == MCX_LONG_CALL_OP |=>
            pc == $past(ex_imm_r) && stack_ptr == $past(stack_ptr) + 1'b1;
    endproperty
    a_call: assert property (p_call)
        else $error("long call target or stack pointer wrong");

    property p_single;
        @(posedge ref_clk) disable iff (!resetn)
        issue && insn_op != MCX_SOFT_INT && insn_op != MCX_LONG_JUMP_OP &&
            insn_op != MCX_LONG_CALL_OP |=> insn_ready ##1 retire;
    endproperty
    a_single: assert property (p_single)
        else $error("single-cycle op stalled or did not retire");
endmodule
`default_nettype wire

// ---- tb_mcx_exec.sv ----
// self-checking bench for the instruction slice executor
`timescale 1ns/1ps
`default_nettype none
module tb_mcx_exec;
    import mcx_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic insn_valid = 1'b0;
    mcx_op_t insn_op = MCX_OR_IMMEDIATE_OP;
    logic [10:0] insn_imm = 11'h000;
    logic insn_dest = 1'b0;
    logic insn_ready;
    logic retire;
    logic [10:0] pc;
    logic [7:0] accumulator;
    logic zero_flag;
    logic [2:0] stack_ptr;
    logic [10:0] stack_top;
    logic [10:0] pc_e = 11'h000;
    logic [10:0] top_e = 11'h000;
    logic [2:0] sp_e = 3'h0;
    int mismatches = 0;
    int comparisons = 0;

    mcx_exec #(.STACK_DEPTH(8)) u_dut (
        .ref_clk(ref_clk), .resetn(resetn), .insn_valid(insn_valid),
        .insn_op(insn_op), .insn_imm(insn_imm), .insn_dest(insn_dest),
        .insn_ready(insn_ready), .retire(retire), .pc(pc),
        .accumulator(accumulator), .zero_flag(zero_flag),
        .stack_ptr(stack_ptr), .stack_top(stack_top)
    );

    // 40 MHz clock
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    // value compare with four-state equality
    task automatic chk(input string n, input logic [10:0] e,
                       input logic [10:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    // verdict and end of run
    task automatic wrap_up;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // issue one instruction, check state, ready gaps and retire pulse
    task automatic run(input mcx_op_t op, input logic [10:0] imm,
                       input logic d, input logic [7:0] ea,
                       input logic ez);
        int w;
        int st;
        w = 0;
        @(negedge ref_clk);
        while (insn_ready !== 1'b1 && w < 20) begin
            @(negedge ref_clk);
            w++;
        end
        chk("wait", 11'h001, 11'(insn_ready));
        insn_valid = 1'b1;
        insn_op = op;
        insn_imm = imm;
        insn_dest = d;
        @(negedge ref_clk);
        insn_valid = 1'b0;
        st = 0;
        case (op)
            MCX_SOFT_INT: begin
                st = 2;
                top_e = pc_e + 11'h001;
                sp_e = sp_e + 3'h1;
                pc_e = MCX_INT_VECTOR;
            end
            MCX_LONG_JUMP_OP: begin
                st = 1;
                pc_e = imm;
            end
            MCX_LONG_CALL_OP: begin
                st = 1;
                top_e = pc_e + 11'h001;
                sp_e = sp_e + 3'h1;
                pc_e = imm;
            end
            default: pc_e = pc_e + 11'h001;
        endcase
        for (int k = 0; k <= 3; k++) begin
            if (k > 0) begin
                @(negedge ref_clk);
            end
            chk("ready", 11'(k >= st), 11'(insn_ready));
            chk("retire", 11'(k == 1), 11'(retire));
            if (k == 1) begin
                chk("pc", pc_e, pc);
                chk("acc", 11'(ea), 11'(accumulator));
                chk("zero", 11'(ez), 11'(zero_flag));
                chk("sp", 11'(sp_e), 11'(stack_ptr));
                chk("top", top_e, stack_top);
            end
        end
    endtask

    // reset values held during reset, then reset released
    task automatic t_reset;
        repeat (8) @(negedge ref_clk);
        chk("rst_ready", 11'h001, 11'(insn_ready));
        chk("rst_retire", 11'h000, 11'(retire));
        chk("rst_pc", MCX_PC_RST, pc);
        chk("rst_acc", 11'(MCX_ACC_RST), 11'(accumulator));
        resetn = 1'b1;
    endtask

    // immediate or into the accumulator
    task automatic t_or_imm;
        run(MCX_OR_IMMEDIATE_OP, 11'h0AA, 1'b0, 8'hAA, 1'b0);
        run(MCX_OR_IMMEDIATE_OP, 11'h050, 1'b0, 8'hFA, 1'b0);
    endtask

    // special page moves, flags untouched, out of window ignored
    task automatic t_special_page;
        run(MCX_WRITE_SPECIAL_PAGE_OP, 11'h0F, 1'b0, 8'hFA, 1'b0);
        run(MCX_READ_SPECIAL_PAGE_OP, 11'h006, 1'b0, 8'h00, 1'b0);
        run(MCX_OR_IMMEDIATE_OP, 11'h000, 1'b0, 8'h00, 1'b1);
        run(MCX_READ_SPECIAL_PAGE_OP, 11'h00F, 1'b0, 8'hFA, 1'b1);
        run(MCX_WRITE_SPECIAL_PAGE_OP, 11'h04, 1'b0, 8'hFA, 1'b1);
        run(MCX_READ_SPECIAL_PAGE_OP, 11'h004, 1'b0, 8'hFA, 1'b1);
        run(MCX_READ_SPECIAL_PAGE_OP, 11'h006, 1'b0, 8'h00, 1'b1);
        run(MCX_READ_SPECIAL_PAGE_OP, 11'h004, 1'b0, 8'h00, 1'b1);
    endtask

    // store and register or, both destinations
    task automatic t_store_or_reg;
        run(MCX_STORE_ACCUMULATOR_OP, 11'h07F, 1'b0, 8'h00, 1'b1);
        run(MCX_OR_REGISTER_OP, 11'h07F, 1'b0, 8'h00, 1'b1);
        run(MCX_READ_SPECIAL_PAGE_OP, 11'h00F, 1'b0, 8'hFA, 1'b1);
        run(MCX_STORE_ACCUMULATOR_OP, 11'h000, 1'b0, 8'hFA, 1'b1);
        run(MCX_READ_SPECIAL_PAGE_OP, 11'h006, 1'b0, 8'h00, 1'b1);
        run(MCX_OR_IMMEDIATE_OP, 11'h005, 1'b0, 8'h05, 1'b0);
        run(MCX_OR_REGISTER_OP, 11'h000, 1'b1, 8'h05, 1'b0);
        run(MCX_READ_SPECIAL_PAGE_OP, 11'h006, 1'b0, 8'h00, 1'b0);
        run(MCX_OR_REGISTER_OP, 11'h000, 1'b0, 8'hFF, 1'b0);
    endtask

    // store then register or on the next edge, read forwarded
    task automatic t_forward;
        run(MCX_READ_SPECIAL_PAGE_OP, 11'h00F, 1'b0, 8'hFA, 1'b0);
        @(negedge ref_clk);
        insn_valid = 1'b1;
        insn_op = MCX_STORE_ACCUMULATOR_OP;
        insn_imm = 11'h055;
        insn_dest = 1'b0;
        @(negedge ref_clk);
        insn_op = MCX_OR_REGISTER_OP;
        @(negedge ref_clk);
        insn_valid = 1'b0;
        pc_e = pc_e + 11'h002;
        @(negedge ref_clk);
        chk("fwd_acc", 11'h0FA, 11'(accumulator));
        chk("fwd_zero", 11'h000, 11'(zero_flag));
        chk("fwd_pc", pc_e, pc);
    endtask

    // jump, call across the pc wrap, software interrupt
    task automatic t_branches;
        run(MCX_LONG_JUMP_OP, 11'h7FF, 1'b0, 8'hFA, 1'b0);
        run(MCX_LONG_CALL_OP, 11'h123, 1'b0, 8'hFA, 1'b0);
        run(MCX_SOFT_INT, 11'h000, 1'b0, 8'hFA, 1'b0);
    endtask

    // main sequence
    initial begin
        t_reset();
        t_or_imm();
        t_special_page();
        t_store_or_reg();
        t_forward();
        t_branches();
        wrap_up();
    end

    // watchdog against a hang
    initial begin
        #(25 * 3000);
        mismatches++;
        wrap_up();
    end
endmodule
`default_nettype wire
